// >>> parallel_nvm_programming_port_tb_top.sv
// self-checking bench for the parallel programming port controller
module parallel_nvm_programming_port_tb_top
    import ppp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // arbitrary signature values
    localparam logic [7:0] SG [3] = '{8'h4A, 8'h6D, 8'h27};
    logic clk_in = 1'b0, resetn_in = 1'b0, vld = 1'b0, p = 1'b0, s = 1'b0;
    logic [3:0] op = 4'h0;
    logic [1:0] act = 2'h3;
    logic [7:0] din = 8'h00, last = 8'h00, bus, cdo, ddo, rdd;
    logic rdy, done, ash, asl, bsp, bss, ls, pl, wrn, oen, coe, doe, rbf;
    int fail_count = 0, check_count = 0;
    always #50 clk_in = ~clk_in;
    // released bus shows the inverse of its last level, not a kind guess
    assign bus = coe ? cdo : doe ? ddo : ~last;
    always @(posedge clk_in) begin
        if (coe || doe)
            last <= bus;
    end
    ppp_ctrl uut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(vld),
        .req_ready_out(rdy), .req_op_in(op), .req_act_in(act), .req_bsel_p_in(p),
        .req_bsel_s_in(s), .req_data_in(din), .done_out(done), .rd_data_out(rdd),
        .action_select_hi_out(ash), .action_select_lo_out(asl),
        .byte_select_primary_out(bsp), .byte_select_secondary_out(bss),
        .load_strobe_out(ls), .page_latch_strobe_out(pl), .write_n_out(wrn),
        .oe_n_out(oen), .data_out(cdo), .data_oe_out(coe), .data_in(bus),
        .ready_busy_flag_in(rbf));
    ppp_dev_model #(.SIG0(SG[0]), .SIG1(SG[1]), .SIG2(SG[2])) dev (.act_in({ash, asl}),
        .bsp_in(bsp), .bss_in(bss), .ls_in(ls), .pl_in(pl), .wr_n_in(wrn), .oe_n_in(oen),
        .data_in(bus), .data_out(ddo), .data_oe_out(doe), .rdy_out(rbf));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // bus turned round around output enable
    always @(negedge clk_in) begin
        if (oen === 1'b0)
            chk("bus_release", {7'h0, coe}, 8'h00);
    end
    task automatic do_op(input logic [3:0] o, input logic [1:0] a, input logic bp,
        input logic bs, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_in);
        {op, act, p, s, din} = {o, a, bp, bs, d};
        vld = 1'b1;
        @(negedge clk_in);
        vld = 1'b0;
        chk("req_ready_busy", {7'h0, rdy}, 8'h00);
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic ld(input logic [1:0] a, input logic bp, input logic [7:0] d);
        do_op(PPP_OP_LOAD, a, bp, 1'b0, d);
    endtask
    task automatic rd8(input logic bp, input logic bs);
        do_op(PPP_OP_READ, ACT_IDLE, bp, bs, 8'h00);
    endtask
    task automatic wr8(input logic bp, input logic bs);
        do_op(PPP_OP_WRITE, ACT_IDLE, bp, bs, 8'h00);
    endtask
    task automatic t_flash();
        ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
        ld(ACT_ADDR, 1'b0, 8'h05);
        ld(ACT_DATA, 1'b0, 8'hA5);
        ld(ACT_DATA, 1'b1, 8'h3C);
        do_op(PPP_OP_LATCH, ACT_IDLE, 1'b1, 1'b0, 8'h00);
        ld(ACT_ADDR, 1'b1, 8'h00);
        wr8(1'b0, 1'b0);
        chk("ready", {7'h0, rbf}, 8'h01);
        ld(ACT_CMD, 1'b0, CMD_NOP);
        ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
        ld(ACT_ADDR, 1'b1, 8'h00);
        ld(ACT_ADDR, 1'b0, 8'h05);
        rd8(1'b0, 1'b0);
        chk("flash_lo", rdd, 8'hA5);
        rd8(1'b1, 1'b0);
        chk("flash_hi", rdd, 8'h3C);
    endtask
    task automatic t_eeprom();
        ld(ACT_CMD, 1'b0, CMD_WR_EEPROM);
        ld(ACT_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < 2; i++) begin
            ld(ACT_ADDR, 1'b0, 8'(7 + i));
            ld(ACT_DATA, 1'b0, 8'(8'h5A + i));
            do_op(PPP_OP_LATCH, ACT_IDLE, 1'b0, 1'b0, 8'h00);
        end
        wr8(1'b0, 1'b0);
        ld(ACT_CMD, 1'b0, CMD_RD_EEPROM);
        for (int i = 0; i < 2; i++) begin
            ld(ACT_ADDR, 1'b0, 8'(7 + i));
            rd8(1'b0, 1'b0);
            chk("eeprom", rdd, 8'(8'h5A + i));
        end
    endtask
    task automatic t_fuse_lock();
        logic [7:0] v [3];
        v = '{8'h62, 8'hD9, 8'hFD};
        for (int i = 0; i < 3; i++) begin
            ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
            ld(ACT_DATA, 1'b0, v[i]);
            wr8(i == 1, i == 2);
            chk("bsel_back", {6'h0, bss, bsp}, 8'h00);
        end
        // mode three first, then try to program boot bits and to clear
        foreach (v[i]) begin
            ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
            ld(ACT_DATA, 1'b0, i == 0 ? 8'hFC : i == 1 ? 8'hC3 : 8'hFF);
            wr8(1'b0, 1'b0);
        end
        ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd8(1'b0, 1'b0);
        chk("fuse_lo", rdd, v[0]);
        rd8(1'b1, 1'b1);
        chk("fuse_hi", rdd, v[1]);
        rd8(1'b0, 1'b1);
        chk("fuse_ext", rdd, v[2]);
        rd8(1'b1, 1'b0);
        chk("lock", rdd, 8'hFC);
    endtask
    task automatic t_sig();
        ld(ACT_CMD, 1'b0, CMD_RD_SIG);
        for (int i = 2; i >= 0; i--) begin
            ld(ACT_ADDR, 1'b0, 8'(i));
            rd8(1'b0, 1'b0);
            chk("signature", rdd, SG[i]);
        end
        ld(ACT_IDLE, 1'b0, 8'h02);
        rd8(1'b0, 1'b0);
        chk("idle_load", rdd, SG[0]);
        rd8(1'b1, 1'b0);
        chk("calibration", rdd, 8'h5C);
    endtask
    initial begin
        repeat (6) @(negedge clk_in);
        resetn_in = 1'b1;
        t_flash();
        t_eeprom();
        t_fuse_lock();
        t_sig();
        tally_and_finish();
    end
endmodule

// >>> ppp_ctrl.sv
// host controller for the high-voltage parallel programming port
// Function
// - address high: act addr, bsel one, strobe
// - write pulse low, wait ready high
// - flash page sequence repeated by user ops
// - nop command ends page programming
// - eeprom page: command, addresses, data, latch
// - eeprom commit: bsel zero, write pulse
// - flash read: low then high byte
// - eeprom read with bsel zero
// - fuse low: command, data, write, wait
// - fuse high: primary one, secondary zero
// - extended fuse: primary zero, secondary one
// - lock bits: command, data, write, wait
// - action bits choose address, data, command, idle
module ppp_ctrl
    import ppp_pkg::*;
(
    input wire logic clk_in, // 10 MHz clock
    input wire logic resetn_in, // sync reset, active low
    input wire logic req_valid_in, // operation request
    output logic req_ready_out, // controller idle
    input wire logic [3:0] req_op_in, // ppp_op_t code
    input wire logic [1:0] req_act_in, // action select for loads
    input wire logic req_bsel_p_in, // primary byte select
    input wire logic req_bsel_s_in, // secondary byte select
    input wire logic [7:0] req_data_in, // byte to load
    output logic done_out, // operation finished, pulse
    output logic [7:0] rd_data_out, // last byte read
    output logic action_select_hi_out, // action bit 1 pin
    output logic action_select_lo_out, // action bit 0 pin
    output logic byte_select_primary_out, // primary byte select pin
    output logic byte_select_secondary_out, // secondary byte select pin
    output logic load_strobe_out, // load strobe pin, pulse high
    output logic page_latch_strobe_out, // page latch pin, pulse high
    output logic write_n_out, // write strobe pin, active low
    output logic oe_n_out, // output enable pin, active low
    output logic [7:0] data_out, // data bus drive value
    output logic data_oe_out, // high while we drive the bus
    input wire logic [7:0] data_in, // data bus level
    input wire logic ready_busy_flag_in // device ready pin
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_PULSE = 7'h04,
        ST_HOLD = 7'h08,
        ST_BUSY = 7'h10,
        ST_WAIT = 7'h20,
        ST_DONE = 7'h40
    } ppp_state_t;

    ppp_state_t state_reg;
    ppp_state_t state_next;
    ppp_op_t op_reg;
    logic [1:0] act_reg;
    logic bsp_reg;
    logic bss_reg;
    logic [7:0] dat_reg;
    logic [7:0] rd_reg;
    logic [1:0] rdy_sync_reg;
    logic [7:0] din_s1_reg;
    logic [7:0] din_s2_reg;
    logic done_reg;
    logic start;
    logic rdy;
    ppp_step_if step ();

    ppp_timer u_timer (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .step(step)
    );

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdy_sync_reg <= 2'h0;
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
        end else begin
            rdy_sync_reg <= {rdy_sync_reg[0], ready_busy_flag_in};
            din_s1_reg <= data_in;
            din_s2_reg <= din_s1_reg;
        end
    end
    assign rdy = rdy_sync_reg[1];

    ////////////////////////////////////////////////////////////////////
    // request capture
    // one page step per request
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            op_reg <= PPP_OP_LOAD;
            act_reg <= ACT_IDLE;
            bsp_reg <= 1'b0;
            bss_reg <= 1'b0;
            dat_reg <= 8'h00;
        end else if (state_reg == ST_IDLE && req_valid_in) begin
            op_reg <= ppp_op_t'(req_op_in);
            act_reg <= req_act_in;
            bsp_reg <= req_bsel_p_in;
            bss_reg <= req_bsel_s_in;
            dat_reg <= req_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer: setup, pulse, hold, each one timer phase
    always_comb begin
        state_next = state_reg;
        start = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid_in) begin
                    state_next = ST_SETUP;
                    start = 1'b1;
                end
            end
            ST_SETUP: begin
                if (step.done) begin
                    state_next = ST_PULSE;
                    start = 1'b1;
                end
            end
            ST_PULSE: begin
                if (step.done) begin
                    state_next = ST_HOLD;
                    start = 1'b1;
                end
            end
            ST_HOLD: begin
                if (step.done) begin
                    if (op_reg == PPP_OP_WRITE) begin
                        state_next = ST_BUSY;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_BUSY: begin
                if (!rdy) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rdy) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end
    assign step.start = start;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read sample and completion
    // read sample
    // the bus arrives two edges late through the synchroniser, so the byte taken
    // at the end of hold is the one seen at the last edge with output enable low
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_reg <= 8'h00;
        end else if (state_reg == ST_HOLD && step.done && op_reg == PPP_OP_READ) begin
            rd_reg <= din_s2_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == ST_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive
    logic active;
    logic pulse;
    assign active = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
    assign pulse = (state_reg == ST_PULSE);
    // action bits idle when not loading
    assign action_select_hi_out = (active && op_reg == PPP_OP_LOAD) ? act_reg[1] : 1'b1;
    assign action_select_lo_out = (active && op_reg == PPP_OP_LOAD) ? act_reg[0] : 1'b1;
    // selects held through the operation, zero afterwards
    assign byte_select_primary_out = active ? bsp_reg : 1'b0;
    assign byte_select_secondary_out = active ? bss_reg : 1'b0;
    assign load_strobe_out = pulse && (op_reg == PPP_OP_LOAD);
    assign page_latch_strobe_out = pulse && (op_reg == PPP_OP_LATCH);
    assign write_n_out = !(pulse && (op_reg == PPP_OP_WRITE));
    // bus released in setup, enable only in pulse, drive again after hold
    assign oe_n_out = !(pulse && (op_reg == PPP_OP_READ));
    assign data_oe_out = !(active && op_reg == PPP_OP_READ);
    assign data_out = dat_reg;
    assign req_ready_out = (state_reg == ST_IDLE);
    assign done_out = done_reg;
    assign rd_data_out = rd_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    // bus released while enabled
    AST_BUS_RELEASE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !oe_n_out |-> !data_oe_out) else $error("bus driven during output enable");
    AST_RELEASE_FIRST: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $fell(oe_n_out) |-> $past(!data_oe_out)) else $error("enable before release");
    AST_LOAD_ACT: assert property (@(posedge clk_in) disable iff (!resetn_in)
        load_strobe_out |-> {action_select_hi_out, action_select_lo_out} == act_reg)
        else $error("load strobe with wrong action");
    AST_WR_WIDTH: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $fell(write_n_out) |-> !write_n_out[*2] ##1 write_n_out)
        else $error("write pulse width wrong");
    AST_WAIT_RDY: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (state_reg == ST_WAIT && !rdy) |=> state_reg != ST_DONE)
        else $error("finished while busy");
    AST_STROBE_EXCL: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !(load_strobe_out && (page_latch_strobe_out || !write_n_out)))
        else $error("two strobes at once");
    AST_SEL_STABLE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !write_n_out |-> $stable(byte_select_primary_out) && $stable(byte_select_secondary_out))
        else $error("select moved during write");
    // selects return to zero after operation
    AST_SEL_ZERO: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out |-> !byte_select_primary_out && !byte_select_secondary_out)
        else $error("select not returned to zero");
    // done follows finish one cycle later
    AST_DONE_PULSE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (state_reg == ST_DONE) |=> done_out ##1 !done_out) else $error("done pulse wrong");
endmodule

// >>> ppp_dev_model.sv
// behavioural model of the device behind the parallel programming port
module ppp_dev_model
    import ppp_pkg::*;
#(
    parameter logic [7:0] SIG0 = 8'h11, // arbitrary signature value
    parameter logic [7:0] SIG1 = 8'h22, // arbitrary signature value
    parameter logic [7:0] SIG2 = 8'h33, // arbitrary signature value
    parameter logic [7:0] CAL = 8'h5C, // arbitrary calibration value
    parameter int BUSY_NS = 1500 // self-timed write length
)(
    input wire logic [1:0] act_in, // action select pins
    input wire logic bsp_in, // primary byte select
    input wire logic bss_in, // secondary byte select
    input wire logic ls_in, // load strobe
    input wire logic pl_in, // page latch strobe
    input wire logic wr_n_in, // write strobe, low pulse
    input wire logic oe_n_in, // output enable, active low
    input wire logic [7:0] data_in, // bus level
    output logic [7:0] data_out, // byte driven on read
    output logic data_oe_out, // high while driving the bus
    output logic rdy_out // ready/busy flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cmd_reg = 8'h00, alo_reg = 8'h00, dlo_reg, dhi_reg, rd_val, lock_reg = 8'hFF;
    logic [7:0] fuse_reg [3] = '{8'hFF, 8'hFF, 8'hFF};
    logic [15:0] buf_reg [256], fl_reg [256], ee_reg [256];
    initial rdy_out = 1'b1;
    always @(posedge ls_in) begin
        case (act_in)
            ACT_ADDR: alo_reg = bsp_in ? alo_reg : data_in;
            ACT_DATA: {dhi_reg, dlo_reg} = bsp_in ? {data_in, dlo_reg} : {dhi_reg, data_in};
            ACT_CMD: cmd_reg = data_in;
            default: ;
        endcase
    end
    always @(posedge pl_in) begin
        buf_reg[alo_reg] = {dhi_reg, dlo_reg};
    end
    always @(negedge wr_n_in) begin
        rdy_out = 1'b0;
        #(BUSY_NS);
        case (cmd_reg)
            CMD_WR_FLASH: fl_reg = buf_reg;
            CMD_WR_EEPROM: ee_reg = buf_reg;
            CMD_WR_FUSE: fuse_reg[{bss_in, bsp_in}] = dlo_reg;
            // bits only get programmed; boot bits frozen in mode three
            CMD_WR_LOCK: lock_reg &= (lock_reg[1:0] == 2'h0) ? (dlo_reg | 8'h3C) : dlo_reg;
            default: ;
        endcase
        rdy_out = 1'b1;
    end
    always_comb begin
        case (cmd_reg)
            CMD_RD_FLASH: rd_val = bsp_in ? fl_reg[alo_reg][15:8] : fl_reg[alo_reg][7:0];
            CMD_RD_EEPROM: rd_val = ee_reg[alo_reg][7:0];
            CMD_RD_FUSE: rd_val = bss_in ? fuse_reg[bsp_in ? 1 : 2] : bsp_in ? lock_reg : fuse_reg[0];
            CMD_RD_SIG: rd_val = bsp_in ? CAL : alo_reg == 0 ? SIG0 : alo_reg == 1 ? SIG1 : SIG2;
            default: rd_val = 8'hFF;
        endcase
    end
    assign data_oe_out = !oe_n_in;
    assign data_out = rd_val;
endmodule

// >>> ppp_pkg.sv
// constants and types shared by the parallel programming port controller
package ppp_pkg;
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
    // pin phase length: 200 ns per step, two cycles at 10 MHz
    localparam int CLK_NS = 100;
    localparam int PHASE_NS = 200;
    localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PHASE_RST = 4'h0;
    // user operation codes
    typedef enum logic [3:0] {
        PPP_OP_LOAD = 4'h0, // one load strobe: act/bsel/data given
        PPP_OP_LATCH = 4'h1, // page latch strobe
        PPP_OP_WRITE = 4'h2, // write strobe then wait ready
        PPP_OP_READ = 4'h3 // release bus, output enable, sample
    } ppp_op_t;
endpackage

// >>> ppp_step_if.sv
// interface between the sequencer and the phase timer
interface ppp_step_if;
    logic start;
    logic done;
    modport seq (output start, input done);
    modport tmr (input start, output done);
endinterface

// >>> ppp_timer.sv
// phase timer: counts one pin phase after each start
module ppp_timer
    import ppp_pkg::*;
(
    input wire logic clk_in, // 10 MHz clock
    input wire logic resetn_in, // sync reset, active low
    ppp_step_if.tmr step // start/done handshake
);
    logic [3:0] cnt_reg;
    logic run_reg;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_reg <= PHASE_RST;
            run_reg <= 1'b0;
        end else if (step.start) begin
            cnt_reg <= PHASE_CYC - 4'h1;
            run_reg <= 1'b1;
        end else if (run_reg) begin
            if (cnt_reg == 4'h0) begin
                run_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
    assign step.done = run_reg && (cnt_reg == 4'h0);
endmodule
